// File: src/iso_spi_defs.svh
// timing constants for the isolated spi channel model
// assumes a 25 mhz system clock (40 ns period)
`ifndef ISO_SPI_DEFS_SVH
`define ISO_SPI_DEFS_SVH
`define CLK_PERIOD_NS      40
`define GLITCH_MIN_NS      10
`define SEL_SETUP_NS       10
`define FAST_DELAY_CYC     1
`define FILT_DELAY_CYC     1
`define DELAYED_CLOCK_OUT_DELAY_CYC     2
`define SAMPLE_PERIOD_NS   2600
`define SAMPLE_PERIOD_CYC  ((`SAMPLE_PERIOD_NS) / (`CLK_PERIOD_NS))
`define SLOW_PROP_NS       100
`define SLOW_PROP_CYC      (((`SLOW_PROP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define REFRESH_NS         1200
`define REFRESH_CYC        ((`REFRESH_NS) / (`CLK_PERIOD_NS))
`define WATCHDOG_NS        5000
`define WATCHDOG_CYC       ((`WATCHDOG_NS) / (`CLK_PERIOD_NS))
`endif

// File: src/iso_spi_pkg.sv
// types shared by the isolated spi channel model
// assumes iso_spi_defs.svh holds all numeric constants
package iso_spi_pkg;
  typedef struct packed {
    logic clk;
    logic data;
    logic sel_n;
  } master_fast_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic sel_n;
    logic slow;
  } packet_t;

  typedef enum logic {
    DIR_FWD,
    DIR_BACK
  } shuttle_dir_t;
endpackage : iso_spi_pkg

// File: src/isolated_spi_channel_model.sv
// behavioural isolated spi channel model, side 1 master, side 2 slave
// assumes all inputs synchronous to sys_clk; no tri-state in design:
// output enables low model the high-z state
`include "iso_spi_defs.svh"
module isolated_spi_channel_model
  import iso_spi_pkg::*;
#(
  parameter bit          FILTERED     = 1'b0,
  parameter int unsigned FAST_DELAY   = `FAST_DELAY_CYC,
  parameter int unsigned FILT_CYC     = `FILT_DELAY_CYC,
  parameter int unsigned DELAYED_CLOCK_OUT_DELAY   = `DELAYED_CLOCK_OUT_DELAY_CYC,
  parameter int unsigned SAMPLE_CYC   = `SAMPLE_PERIOD_CYC,
  parameter int unsigned SLOW_CYC     = `SLOW_PROP_CYC,
  parameter int unsigned REFRESH_CYC  = `REFRESH_CYC,
  parameter int unsigned WATCHDOG_CYC = `WATCHDOG_CYC
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // side 1 master pins
  input  wire iso_spi_pkg::master_fast_t master_in,
  output logic               master_data_in_out,
  output logic               master_data_in_oe,
  output logic               delayed_clock_out,
  output logic               slow_output_b,
  output logic               slow_output_b_oe,
  // side 1 slow input
  input  wire logic          slow_input_a,
  // side 2 slave pins
  input  wire logic          slave_data_in,
  input  wire logic          slow_input_b,
  output logic               slave_clock_out,
  output logic               slave_data_out,
  output logic               slave_select_out,
  output logic               side2_oe,
  output logic               slow_output_a,
  // side power, high while powered
  input  wire logic          side1_powered,
  input  wire logic          side2_powered
);
  import iso_spi_pkg::*;

  localparam int unsigned LAT = FAST_DELAY + (FILTERED ? FILT_CYC : 0);
  localparam int unsigned SLAT = FAST_DELAY + FILT_CYC;

  initial begin
    if (FAST_DELAY < 1 || FILT_CYC < 1 || SAMPLE_CYC < 2 ||
        WATCHDOG_CYC <= SAMPLE_CYC || DELAYED_CLOCK_OUT_DELAY < 1 || LAT > 15 ||
        SLAT > 15 || SLOW_CYC < 1 || SLOW_CYC >= SAMPLE_CYC)
      $error("isolated_spi_channel_model: bad parameters");
  end

  // ==========================================
  // fast paths: plain delay lines, mode agnostic
  logic [15:0] clk_dl_reg, mo_dl_reg, mi_dl_reg, ss_dl_reg;
  logic [15:0] delayed_clock_out_dl_reg;
  logic        clk_f, mo_f, mi_f, ss_f;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_dl_reg  <= 16'h0000;
      mo_dl_reg   <= 16'h0000;
      mi_dl_reg   <= 16'h0000;
      ss_dl_reg   <= 16'hffff;
      delayed_clock_out_dl_reg <= 16'h0000;
    end else begin
      clk_dl_reg  <= {clk_dl_reg[14:0], master_in.clk};
      mo_dl_reg   <= {mo_dl_reg[14:0], master_in.data};
      mi_dl_reg   <= {mi_dl_reg[14:0], slave_data_in};
      ss_dl_reg   <= {ss_dl_reg[14:0], master_in.sel_n};
      delayed_clock_out_dl_reg <= {delayed_clock_out_dl_reg[14:0], master_in.clk};
    end
  end

  // ==========================================
  // glitch filter: output follows only a level held FILT_CYC+1 samples
  // filter on select always; on clock and data only in filtered grade
  function automatic logic stable(input logic [15:0] d, input int n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i <= n; i++) begin
      if (d[i] != d[0])
        ok = 1'b0;
    end
    return ok;
  endfunction : stable

  logic clk_q_reg, mo_q_reg, mi_q_reg, ss_q_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q_reg <= 1'b0;
      mo_q_reg  <= 1'b0;
      mi_q_reg  <= 1'b0;
      ss_q_reg  <= 1'b1;
    end else begin
      if (!FILTERED || stable(clk_dl_reg, FILT_CYC))
        clk_q_reg <= clk_dl_reg[FAST_DELAY-1];
      if (!FILTERED || stable(mo_dl_reg, FILT_CYC))
        mo_q_reg <= mo_dl_reg[FAST_DELAY-1];
      if (!FILTERED || stable(mi_dl_reg, FILT_CYC))
        mi_q_reg <= mi_dl_reg[FAST_DELAY-1];
      if (stable(ss_dl_reg, FILT_CYC))
        ss_q_reg <= ss_dl_reg[FAST_DELAY-1];
    end
  end
  // no bus-clock sampling anywhere; paths just delay levels
  assign clk_f = clk_q_reg;
  assign mo_f  = mo_q_reg;
  assign mi_f  = mi_q_reg;
  assign ss_f  = ss_q_reg;

  // ==========================================
  // shuttle: free-running sample clock, alternating packets
  logic [15:0]  tick_reg;
  shuttle_dir_t dir_reg;
  packet_t      pkt_reg;
  logic [15:0]  prop_reg;
  logic         prop_busy_reg;
  logic         sample;

  assign sample = (tick_reg == 16'(SAMPLE_CYC - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 16'h0000;
      dir_reg  <= DIR_FWD;
    end else if (sample) begin
      tick_reg <= 16'h0000;
      dir_reg  <= (dir_reg == DIR_FWD) ? DIR_BACK : DIR_FWD;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  // each side sends only while powered; levels captured together
  logic send_ok;
  assign send_ok = (dir_reg == DIR_FWD) ? side1_powered : side2_powered;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_reg       <= '0;
      prop_reg      <= 16'h0000;
      prop_busy_reg <= 1'b0;
    end else if (sample && send_ok) begin
      if (dir_reg == DIR_FWD)
        pkt_reg <= '{master_in.clk, master_in.data, master_in.sel_n,
                     slow_input_a};
      else
        pkt_reg <= '{1'b0, slave_data_in, 1'b1, slow_input_b};
      prop_reg      <= 16'(SLOW_CYC);
      prop_busy_reg <= 1'b1;
    end else if (prop_busy_reg) begin
      prop_reg      <= prop_reg - 16'h0001;
      prop_busy_reg <= (prop_reg != 16'h0001);
    end
  end

  logic arrive;
  assign arrive = prop_busy_reg && (prop_reg == 16'h0001);

  // ==========================================
  // receive: slow outputs, refresh of fast levels, watchdog
  logic         slow_a_reg, slow_b_reg;
  shuttle_dir_t rx_dir_reg;
  logic [15:0]  wd1_reg, wd2_reg;
  logic [15:0]  idle_reg;
  logic         refresh_clk_reg, refresh_mo_reg, refresh_mi_reg;
  logic         refresh_pend_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rx_dir_reg <= DIR_FWD;
    else if (sample && send_ok)
      rx_dir_reg <= dir_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_a_reg <= 1'b0;
      slow_b_reg <= 1'b0;
    end else if (arrive) begin
      if (rx_dir_reg == DIR_FWD)
        slow_a_reg <= pkt_reg.slow;
      else
        slow_b_reg <= pkt_reg.slow;
    end
  end

  // idle counter on fast inputs; a refresh re-applies packet levels
  logic any_edge;
  assign any_edge = (clk_dl_reg[0] != master_in.clk) ||
                    (mo_dl_reg[0] != master_in.data) ||
                    (mi_dl_reg[0] != slave_data_in);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg         <= 16'h0000;
      refresh_pend_reg <= 1'b0;
    end else begin
      if (any_edge)
        idle_reg <= 16'h0000;
      else if (idle_reg != 16'(REFRESH_CYC))
        idle_reg <= idle_reg + 16'h0001;
      refresh_pend_reg <= (idle_reg == 16'(REFRESH_CYC)) && arrive;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_clk_reg <= 1'b0;
      refresh_mo_reg  <= 1'b0;
      refresh_mi_reg  <= 1'b0;
    end else if (arrive) begin
      if (rx_dir_reg == DIR_FWD) begin
        refresh_clk_reg <= pkt_reg.clk;
        refresh_mo_reg  <= pkt_reg.data;
      end else begin
        refresh_mi_reg  <= pkt_reg.data;
      end
    end
  end

  // watchdog per receiving side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd1_reg <= 16'h0000;
      wd2_reg <= 16'h0000;
    end else begin
      if (arrive && rx_dir_reg == DIR_FWD)
        wd2_reg <= 16'h0000;
      else if (wd2_reg != 16'(WATCHDOG_CYC))
        wd2_reg <= wd2_reg + 16'h0001;
      if (arrive && rx_dir_reg == DIR_BACK)
        wd1_reg <= 16'h0000;
      else if (wd1_reg != 16'(WATCHDOG_CYC))
        wd1_reg <= wd1_reg + 16'h0001;
    end
  end

  logic side1_alive, side2_alive;
  assign side2_alive = (wd2_reg != 16'(WATCHDOG_CYC)) && side2_powered;
  assign side1_alive = (wd1_reg != 16'(WATCHDOG_CYC)) && side1_powered;

  // ==========================================
  // outputs; in the unfiltered grade only, a refresh overrides a level lost to a short glitch
  // a refresh only touches the paths its packet carried; the other
  // side's stored level may be stale
  logic use_ref, use_ref_fwd, use_ref_back;
  assign use_ref      = refresh_pend_reg && !FILTERED;
  assign use_ref_fwd  = use_ref && (rx_dir_reg == DIR_FWD);
  assign use_ref_back = use_ref && (rx_dir_reg == DIR_BACK);

  assign slave_clock_out    = use_ref_fwd ? refresh_clk_reg : clk_f;
  assign slave_data_out     = use_ref_fwd ? refresh_mo_reg : mo_f;
  assign slave_select_out   = ss_f;
  assign side2_oe           = side2_alive;
  assign slow_output_a      = slow_a_reg;
  assign master_data_in_out = use_ref_back ? refresh_mi_reg : mi_f;
  assign master_data_in_oe  = side1_alive;
  assign slow_output_b      = slow_b_reg;
  assign slow_output_b_oe   = side1_alive;
  assign delayed_clock_out  = delayed_clock_out_dl_reg[DELAYED_CLOCK_OUT_DELAY-1];

  // ==========================================
  // checks
  a_sel_filter_holds: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(ss_q_reg) |-> $past(stable(ss_dl_reg, FILT_CYC)))
    else $error("select changed without stable input");
  a_dir_alternates: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sample |=> dir_reg != $past(dir_reg))
    else $error("shuttle direction did not alternate");
  sequence s_sampled;
    sample && send_ok;
  endsequence
  a_slow_latency: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_sampled |-> ##(SLOW_CYC) arrive)
    else $error("slow packet arrival late");
  a_watchdog_hiz: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wd2_reg == 16'(WATCHDOG_CYC)) |-> !side2_oe)
    else $error("side 2 driven with no packets");
  a_side1_hiz: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wd1_reg == 16'(WATCHDOG_CYC)) |-> !master_data_in_oe)
    else $error("side 1 driven with no packets");
  a_slow_out_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !arrive |=> ($stable(slow_output_a) && $stable(slow_output_b)))
    else $error("slow output moved without a packet");
  a_delayed_clock_out_copy: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    delayed_clock_out == $past(master_in.clk, DELAYED_CLOCK_OUT_DELAY))
    else $error("delayed clock is not a fixed-delay copy");
endmodule : isolated_spi_channel_model

// File: testbench/spi_slave_model.sv
// spi slave partner on side 2 of the isolated channel model
// assumes mode 0 framing, select active low, all on sys_clk
module spi_slave_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // side 2 bus
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic sel_n,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // shifter: next frame echoes the last one
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic       sclk_reg;
  logic       sel_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg   <= 8'h00;
      tx_reg   <= 8'h00;
      sclk_reg <= 1'b0;
      sel_reg  <= 1'b1;
      miso     <= 1'b0;
    end else begin
      sclk_reg <= sclk;
      sel_reg  <= sel_n;
      if (sel_n) begin
        // released line has no pull: keep it moving
        miso <= ~miso;
        if (!sel_reg) begin
          tx_reg <= rx_reg;
        end
      end else if (sel_reg) begin
        miso <= tx_reg[7];
      end else if (sclk && !sclk_reg) begin
        rx_reg <= {rx_reg[6:0], mosi};
      end else if (!sclk && sclk_reg) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        miso   <= tx_reg[6];
      end
    end
  end
endmodule : spi_slave_model

// File: testbench/isolated_spi_channel_model_tb.sv
// self-checking bench for the isolated spi channel model
// assumes spi_slave_model on side 2; master and slow inputs driven here
module isolated_spi_channel_model_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iso_spi_pkg::*;
  // ==========================================
  // signals
  localparam int SAMP  = 8;
  localparam int WDOGC = 20;
  localparam int WAITC = 2 * SAMP + 3 + 4;
  logic         sys_clk       = 1'b0;
  logic         rst_n         = 1'b0;
  master_fast_t m             = '{clk: 1'b0, data: 1'b0, sel_n: 1'b1};
  logic         slow_input_a  = 1'b0;
  logic         slow_input_b  = 1'b0;
  logic         side1_powered = 1'b1;
  logic         side2_powered = 1'b1;
  logic         slave_data_in, master_data_in_out, master_data_in_oe;
  logic         delayed_clock_out, slow_output_b, slow_output_b_oe;
  logic         slave_clock_out, slave_data_out, slave_select_out;
  logic         side2_oe, slow_output_a, mon_en, delayed_clock_out_prev, b;
  logic [7:0]   cap;
  logic [4:0]   sv;
  logic [3:0]   hist[$];
  logic [7:0]   exp_q[$];
  int           err_count = 0;
  int           tests_run = 0;
  int unsigned  seed;
  // ==========================================
  // design and partner
  isolated_spi_channel_model #(.SAMPLE_CYC(SAMP), .SLOW_CYC(3),
    .REFRESH_CYC(4), .WATCHDOG_CYC(WDOGC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .master_in(m),
    .master_data_in_out(master_data_in_out),
    .master_data_in_oe(master_data_in_oe),
    .delayed_clock_out(delayed_clock_out), .slow_output_b(slow_output_b),
    .slow_output_b_oe(slow_output_b_oe), .slow_input_a(slow_input_a),
    .slave_data_in(slave_data_in), .slow_input_b(slow_input_b),
    .slave_clock_out(slave_clock_out), .slave_data_out(slave_data_out),
    .slave_select_out(slave_select_out), .side2_oe(side2_oe),
    .slow_output_a(slow_output_a), .side1_powered(side1_powered),
    .side2_powered(side2_powered));
  spi_slave_model i_slave (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(slave_clock_out), .mosi(slave_data_out),
    .sel_n(slave_select_out), .miso(slave_data_in));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================
  // compare and closing
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic give_verdict;
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wait_oe(input int s, input logic v);
    for (int n = 0; n < 3 * WDOGC; n++) begin
      @(posedge sys_clk);
      #1;
      if ((s ? master_data_in_oe : side2_oe) === v) break;
    end
  endtask : wait_oe
  // ==========================================
  // fast path model: two edges, select only once steady
  always @(posedge sys_clk) begin
    #1;
    hist.push_front({m, slave_data_in});
    if (hist.size() > 6) void'(hist.pop_back());
    if (mon_en === 1'b1 && hist.size() == 6) begin
      chk1(slave_clock_out, hist[2][3]);
      chk1(delayed_clock_out, hist[2][3]);
      chk1(slave_data_out, hist[2][2]);
      chk1(master_data_in_out, hist[2][0]);
      sv = {hist[1][1], hist[2][1], hist[3][1], hist[4][1], hist[5][1]};
      if (sv == 5'h00 || sv == 5'h1f) chk1(slave_select_out, sv[0]);
    end
    if (delayed_clock_out_prev === 1'b0 && delayed_clock_out === 1'b1) begin
      cap = {cap[6:0], master_data_in_out};
    end
    delayed_clock_out_prev = delayed_clock_out;
  end
  // ==========================================
  // master frame at 3.125 mhz, well under 17 mhz
  task automatic spi_xfer(input logic [7:0] tx);
    @(posedge sys_clk);
    m.sel_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (int k = 7; k >= 0; k--) begin
      m.data <= tx[k];
      repeat (4) @(posedge sys_clk);
      m.clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      m.clk <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    m.sel_n <= 1'b1;
    chk8(cap, exp_q.pop_front());
    exp_q.push_back(tx);
    repeat (8) @(posedge sys_clk);
  endtask : spi_xfer
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
  initial begin
    mon_en = 1'b0;
    seed = $urandom(15);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    mon_en = 1'b1;
    exp_q.push_back(8'h00);
    spi_xfer(8'hff);
    for (int i = 0; i < 6; i++) begin
      spi_xfer(8'($urandom));
    end
    spi_xfer(8'h00);
    // one-cycle select pulse must not reach side 2
    @(posedge sys_clk);
    m.sel_n <= 1'b0;
    @(posedge sys_clk);
    m.sel_n <= 1'b1;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      chk1(slave_select_out, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      b = 1'($urandom);
      @(posedge sys_clk);
      slow_input_a <= ~slow_input_a;
      slow_input_b <= b;
      for (int n = 0; n < WAITC; n++) begin
        @(posedge sys_clk);
        #1;
        if (slow_output_a === slow_input_a && slow_output_b === b) break;
      end
      chk1(slow_output_a, slow_input_a);
      chk1(slow_output_b, b);
    end
    mon_en = 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      if (s == 0) side1_powered <= 1'b0;
      else side2_powered <= 1'b0;
      wait_oe(s, 1'b0);
      chk1(s ? master_data_in_oe : side2_oe, 1'b0);
      chk1(slow_output_b_oe, 1'b0);
      @(posedge sys_clk);
      side1_powered <= 1'b1;
      side2_powered <= 1'b1;
      wait_oe(s, 1'b1);
      chk1(s ? master_data_in_oe : side2_oe, 1'b1);
      chk1(slow_output_b_oe, 1'b1);
    end
    give_verdict();
  end
endmodule : isolated_spi_channel_model_tb
